// ==== dv/cfg_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module cfg_props
	import codec_cfg_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        ce,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        sample_valid,
	input wire logic        rec_l_valid,
	input wire logic [1:0]  adc_slot_pair,
	input wire logic [2:0]  tdm_left_slot,
	input wire logic [1:0]  adc_channel_enable,
	input wire logic [7:0]  left_input_atten,
	input wire logic [3:0]  lmix_aux_gain,
	input wire logic [5:0]  lmix_aux_db,
	input wire logic [5:0]  mix_gain_mute,
	input wire logic [1:0]  lineout_l_from_lmix_boost,
	input wire logic        lineout_l_mixer_enable,
	input wire logic        lineout_l_lmix_on
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	function automatic logic [5:0] db_of(input logic [3:0] c);
		return (c == 4'h0 || c > 4'h8) ? 6'h00 : 6'({2'b00, c} * 6'h03 - 6'h12);
	endfunction

	// ==========================================================
	// register port
	sequence s_wr(logic [15:0] a);
		ce && reg_wr && reg_addr == a;
	endsequence
	property p_tdm_wr;
		s_wr(OFS_TDM) |=> adc_slot_pair == 2'($past(reg_wdata));
	endproperty
	a_tdm_wr: assert property (p_tdm_wr) else $error("slot pair not taken");
	property p_adc_wr;
		s_wr(OFS_ADC) |=> adc_channel_enable == 2'($past(reg_wdata));
	endproperty
	a_adc_wr: assert property (p_adc_wr) else $error("adc enable not taken");
	property p_slot;
		s_wr(OFS_TDM) |=> tdm_left_slot == {$past(reg_wdata[1:0]), 1'b0};
	endproperty
	a_slot: assert property (p_slot) else $error("tdm slot wrong");
	// a read racing a write must still return the old value
	property p_rd_tdm;
		ce && reg_rd && reg_addr == OFS_TDM |=> reg_rdata == {6'h00, $past(adc_slot_pair)};
	endproperty
	a_rd_tdm: assert property (p_rd_tdm) else $error("pair readback wrong");
	property p_rd_unmapped;
		ce && reg_rd && (reg_addr < OFS_TDM || reg_addr > OFS_LOUT) |=> reg_rdata == 8'h00;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

	// ==========================================================
	// decoded gains, slew and record path
	property p_aux_db;
		ce |=> lmix_aux_db == db_of($past(lmix_aux_gain));
	endproperty
	a_aux_db: assert property (p_aux_db) else $error("aux gain decode wrong");
	property p_aux_mute;
		ce |=> mix_gain_mute[0] == ($past(lmix_aux_gain) == 4'h0 || $past(lmix_aux_gain) > 4'h8);
	endproperty
	a_aux_mute: assert property (p_aux_mute) else $error("aux mute wrong");
	property p_lo_on;
		ce |=> lineout_l_lmix_on == ($past(lineout_l_mixer_enable)
			&& $past(lineout_l_from_lmix_boost) inside {2'b01, 2'b10});
	endproperty
	a_lo_on: assert property (p_lo_on) else $error("line-out path wrong");
	property p_slew;
		ce |=> left_input_atten == $past(left_input_atten)
			|| left_input_atten == 8'($past(left_input_atten) + 8'h01)
			|| left_input_atten == 8'($past(left_input_atten) - 8'h01);
	endproperty
	a_slew: assert property (p_slew) else $error("attenuation jumped");
	sequence s_rec_l;
		ce && sample_valid && adc_channel_enable[0] ##1 ce && adc_channel_enable[0];
	endsequence
	property p_rec;
		s_rec_l |=> rec_l_valid;
	endproperty
	a_rec: assert property (p_rec) else $error("left record valid missing");
	property p_rec_src;
		rec_l_valid && $past(ce) && $past(ce, 2) |-> $past(sample_valid, 2);
	endproperty
	a_rec_src: assert property (p_rec_src) else $error("left record valid unprompted");
endmodule // cfg_props

bind codec_adc_mixer_config_regs cfg_props u_props (.*);
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import codec_cfg_pkg::*;
	// ==========================================================
	// ports
	logic        ref_clk = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0, sample_valid = 0;
	logic [15:0] reg_addr = '0;
	logic [7:0]  reg_wdata = '0, reg_rdata, left_input_atten, right_input_atten;
	logic [23:0] adc_l_sample = '0, adc_r_sample = '0, dmic_l_sample = '0;
	logic [23:0] dmic_r_sample = '0, rec_l_sample, rec_r_sample;
	logic        rec_l_valid, rec_r_valid, adc_highpass_on, input_source_select;
	logic        atten_settled, lmix_rdac_unmute, lmix_ldac_unmute, lmix_enable;
	logic        rmix_rdac_unmute, rmix_ldac_unmute, rmix_enable;
	logic        lineout_l_mixer_enable, lineout_l_rmix_on, lineout_l_lmix_on;
	logic [1:0]  adc_slot_pair, adc_channel_enable;
	logic [1:0]  lineout_l_from_rmix_boost, lineout_l_from_lmix_boost;
	logic [2:0]  tdm_left_slot, tdm_right_slot;
	logic [3:0]  lmix_aux_gain, lmix_lbypass_gain, lmix_rbypass_gain;
	logic [3:0]  rmix_aux_gain, rmix_lbypass_gain, rmix_rbypass_gain;
	logic [5:0]  lmix_aux_db, lmix_lbypass_db, lmix_rbypass_db, mix_gain_mute;
	logic [5:0]  rmix_aux_db, rmix_lbypass_db, rmix_rbypass_db;
	int          n_errors = 0, checks_done = 0;
	logic [7:0]  shadow [9];

	codec_adc_mixer_config_regs uut (.*);

	always #2.5 ref_clk = ~ref_clk;

	// ==========================================================
	// expectations
	function automatic logic [7:0] msk(input logic [3:0] i);
		case (i)
			4'h0: return 8'h03;
			4'h1, 4'h4, 4'h6: return 8'h7f;
			4'h8: return 8'h1f;
			default: return 8'hff;
		endcase
	endfunction
	function automatic logic gm(input logic [3:0] c);
		return c == 4'h0 || c > 4'h8;
	endfunction
	function automatic logic [5:0] gdb(input logic [3:0] c);
		return gm(c) ? 6'h00 : 6'({2'b00, c} * 6'h03 - 6'h12);
	endfunction
	function automatic logic [23:0] rexp(input logic [7:0] c, input logic r);
		logic [23:0] x;
		if (c[2]) begin
			x = (c[3] ^ r) ? dmic_r_sample : dmic_l_sample;
			if (!c[4]) x = -x;
		end else begin
			x = r ? adc_r_sample : adc_l_sample;
			if (c[6]) x = -x;
		end
		return x;
	endfunction

	// ==========================================================
	// drivers and checks
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc();
		reg_wr = 0;
		if (ce && a >= 16'h4018 && a <= 16'h4020) shadow[4'(a - 16'h4018)] = d & msk(4'(a - 16'h4018));
		cyc();
	endtask
	task automatic rd(input logic [15:0] a);
		reg_addr = a;
		reg_rd = 1;
		cyc();
		reg_rd = 0;
		chk(reg_rdata, (a >= 16'h4018 && a <= 16'h4020) ? shadow[4'(a - 16'h4018)] : 8'h00);
		cyc();
	endtask
	task automatic fields;
		chk({adc_slot_pair, tdm_left_slot, tdm_right_slot}, {shadow[0][1:0],
			shadow[0][1:0], 1'b0, shadow[0][1:0], 1'b1});
		chk({adc_highpass_on, input_source_select, adc_channel_enable},
			{shadow[1][5], shadow[1][2:0]});
		chk({lmix_rdac_unmute, lmix_ldac_unmute, lmix_aux_gain, lmix_enable,
			lmix_rbypass_gain, lmix_lbypass_gain}, {shadow[4][6:0], shadow[5]});
		chk({rmix_rdac_unmute, rmix_ldac_unmute, rmix_aux_gain, rmix_enable,
			rmix_rbypass_gain, rmix_lbypass_gain}, {shadow[6][6:0], shadow[7]});
		chk({lmix_aux_db, lmix_lbypass_db, lmix_rbypass_db, rmix_aux_db, rmix_lbypass_db,
			rmix_rbypass_db}, {gdb(shadow[4][4:1]), gdb(shadow[5][3:0]), gdb(shadow[5][7:4]),
			gdb(shadow[6][4:1]), gdb(shadow[7][3:0]), gdb(shadow[7][7:4])});
		chk(mix_gain_mute, {gm(shadow[7][7:4]), gm(shadow[7][3:0]), gm(shadow[6][4:1]),
			gm(shadow[5][7:4]), gm(shadow[5][3:0]), gm(shadow[4][4:1])});
		chk({lineout_l_from_rmix_boost, lineout_l_from_lmix_boost, lineout_l_mixer_enable,
			lineout_l_rmix_on, lineout_l_lmix_on}, {shadow[8][4:0],
			shadow[8][0] && shadow[8][4:3] inside {2'b01, 2'b10},
			shadow[8][0] && shadow[8][2:1] inside {2'b01, 2'b10}});
	endtask
	// keep reuses the previous samples so a filter step can be predicted exactly
	task automatic samp(input bit keep);
		if (!keep) begin
			adc_l_sample = 24'($urandom_range(24'h7fffff));
			adc_r_sample = 24'($urandom_range(24'h7fffff));
			dmic_l_sample = 24'($urandom_range(24'h7fffff));
			dmic_r_sample = 24'($urandom_range(24'h7fffff));
		end
		sample_valid = 1;
		cyc();
		sample_valid = 0;
		cyc();
		chk({rec_l_valid, rec_r_valid}, {shadow[1][0], shadow[1][1]});
		cyc();
	endtask
	task automatic settle;
		int k;
		k = 0;
		while (atten_settled !== 1'b1 && k < 8000) begin
			cyc();
			k++;
		end
		chk(k < 8000, 1);
	endtask
	task automatic do_reset(input int n);
		nrst = 0;
		cyc(n);
		nrst = 1;
		foreach (shadow[i]) shadow[i] = (i == 1) ? 8'h10 : 8'h00;
		for (int i = 0; i < 9; i++) rd(16'h4018 + 16'(i));
		fields();
	endtask
	task automatic end_sim;
		if (n_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	initial begin
		logic [15:0] a;
		logic [7:0]  c;
		void'($urandom(83));
		do_reset(20);
		// unmapped neighbours on both sides are drawn too
		for (int i = 0; i < 60; i++) begin
			a = 16'h4016 + 16'($urandom_range(12));
			wr(a, 8'($urandom));
			rd(a);
			fields();
		end
		for (int i = 0; i < 16; i++) begin
			c = 8'(i);
			wr(16'h401c, {3'b110, c[3:0], c[0]});
			wr(16'h401d, {c[3:0], ~c[3:0]});
			wr(16'h401e, {3'b101, ~c[3:0], ~c[0]});
			wr(16'h401f, {~c[3:0], c[3:0]});
			wr(16'h4020, {3'b111, c[3:0], c[1]});
			rd(16'h4020);
			fields();
		end
		wr(16'h401a, 8'h00);
		wr(16'h401b, 8'h00);
		settle();
		for (int i = 0; i < 24; i++) begin
			wr(16'h4019, 8'($urandom) & 8'h5f);
			samp(0);
			chk(rec_l_sample, shadow[1][0] ? rexp(shadow[1], 0) : 24'h0);
			chk(rec_r_sample, shadow[1][1] ? rexp(shadow[1], 1) : 24'h0);
		end
		wr(16'h4019, 8'h33);
		samp(0);
		chk(rec_l_sample, rexp(shadow[1], 0));
		samp(1);
		chk(rec_l_sample, 24'($signed(rexp(shadow[1], 0)) - ($signed(rexp(shadow[1], 0)) >>> 12)));
		wr(16'h401a, 8'h10);
		wr(16'h401b, 8'h20);
		cyc(3);
		chk(left_input_atten < 8'h02, 1);
		settle();
		chk({left_input_atten, right_input_atten}, 16'h1020);
		for (int j = 0; j < 2; j++) begin
			wr(16'h4019, (j == 1) ? 8'h17 : 8'h13);
			samp(0);
			chk(rec_l_sample, 24'($signed(rexp(shadow[1], 0)) >>> 1));
			chk(rec_r_sample, 24'($signed(rexp(shadow[1], 1)) >>> 2));
		end
		ce = 0;
		wr(16'h4018, 8'h03);
		ce = 1;
		rd(16'h4018);
		wr(16'h4018, 8'hfe);
		rd(16'h4018);
		fields();
		do_reset(3);
		end_sim();
	end

	initial begin
		// scenarios need under 10000 cycles
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		end_sim();
	end
endmodule // tb_top
`default_nettype wire

// ==== hw/atten_slew.sv ====
`timescale 1ns/10ps
`default_nettype none

// walks the applied attenuation one code at a time toward the target
module atten_slew
	import codec_cfg_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       ce,
	input  wire logic [7:0] target,
	output var  logic [7:0] level_q,
	output var  logic       settled_q
);

	logic [SLEW_CNT_W-1:0] tick_q;
	logic                  tick;

	assign tick = tick_q == SLEW_CNT_W'(SLEW_STEP_CYCLES - 1);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tick_q <= '0;
		end else if (ce) begin
			tick_q <= tick ? '0 : tick_q + 1'b1;
		end
	end

	// gradual steps avoid zipper noise on large volume changes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			level_q <= 8'h00;
		end else if (ce && tick) begin
			if (level_q < target) begin
				level_q <= level_q + 8'h01; // RL7
			end else if (level_q > target) begin
				level_q <= level_q - 8'h01; // RL7
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			settled_q <= 1'b1;
		end else if (ce) begin
			settled_q <= level_q == target;
		end
	end

endmodule // atten_slew

`default_nettype wire

// ==== hw/codec_adc_mixer_config_regs.sv ====
// Summary of operation
// (RL1) The adc record pair sits in tdm slot pair 0..3 as chosen by a two-bit field, first by default.
// (RL2) Bit 6 of adc control inverts the adc input polarity when set, normal after reset.
// (RL3) Bit 5 switches on a high-pass filter with a corner near 2 Hz at 48 kHz, off after reset.
// (RL4) Bit 4 clear inverts microphone data, set (the reset value) passes it unchanged.
// (RL5) Bit 3 set exchanges the left and right microphone channels.
// (RL6) The two low bits enable no adc, left only, right only or both, none after reset.
// (RL7) Each channel volume attenuates 0.375 dB per code from 0 dB at zero and slews to new settings.
// (RL8) Channel volume applies to that side's record data from either the adc or the microphone.
// (RL9) Left playback mixer bits 6 and 5 unmute the right and left dac inputs, muted after reset.
// (RL10) Left mixer aux gain in bits 4..1 mutes at zero and runs -15 dB to +6 dB in 3 dB steps.
// (RL11) Bit 0 of the left playback mixer enables it, disabled after reset.
// (RL12) Each playback mixer has right bypass gain in the high nibble and left in the low nibble.
// (RL13) Right playback mixer bits 6 and 5 unmute the right and left dac inputs, muted after reset.
// (RL14) Right mixer aux gain in bits 4..1 is coded like the left one and resets to mute.
// (RL15) Bit 0 of the right playback mixer enables it, disabled after reset.
// (RL16) Line-out boost fields mute at 00, give 0 dB at 01 and 6 dB at 10; bit 0 enables the mixer.
// (RL17) Software writes zero to reserved bits and uses no reserved codes; reserved bits read zero.
`timescale 1ns/10ps
`default_nettype none

module codec_adc_mixer_config_regs
	import codec_cfg_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	// register port
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output var  logic [7:0]  reg_rdata,
	// record samples in
	input  wire logic        sample_valid,
	input  wire logic [23:0] adc_l_sample,
	input  wire logic [23:0] adc_r_sample,
	input  wire logic [23:0] dmic_l_sample,
	input  wire logic [23:0] dmic_r_sample,
	// record samples out
	output var  logic [23:0] rec_l_sample,
	output var  logic [23:0] rec_r_sample,
	output var  logic        rec_l_valid,
	output var  logic        rec_r_valid,
	// adc and tdm state
	output var  logic [1:0]  adc_slot_pair,
	output var  logic [2:0]  tdm_left_slot,
	output var  logic [2:0]  tdm_right_slot,
	output var  logic [1:0]  adc_channel_enable,
	output var  logic        adc_highpass_on,
	output var  logic        input_source_select,
	output var  logic [7:0]  left_input_atten,
	output var  logic [7:0]  right_input_atten,
	output var  logic        atten_settled,
	// playback mixers
	output var  logic        lmix_rdac_unmute,
	output var  logic        lmix_ldac_unmute,
	output var  logic [3:0]  lmix_aux_gain,
	output var  logic        lmix_enable,
	output var  logic [3:0]  lmix_lbypass_gain,
	output var  logic [3:0]  lmix_rbypass_gain,
	output var  logic        rmix_rdac_unmute,
	output var  logic        rmix_ldac_unmute,
	output var  logic [3:0]  rmix_aux_gain,
	output var  logic        rmix_enable,
	output var  logic [3:0]  rmix_lbypass_gain,
	output var  logic [3:0]  rmix_rbypass_gain,
	// decoded mixer gains, signed dB, with mute flags
	output var  logic [5:0]  lmix_aux_db,
	output var  logic [5:0]  lmix_lbypass_db,
	output var  logic [5:0]  lmix_rbypass_db,
	output var  logic [5:0]  rmix_aux_db,
	output var  logic [5:0]  rmix_lbypass_db,
	output var  logic [5:0]  rmix_rbypass_db,
	output var  logic [5:0]  mix_gain_mute,
	// left line-out mixer
	output var  logic [1:0]  lineout_l_from_rmix_boost,
	output var  logic [1:0]  lineout_l_from_lmix_boost,
	output var  logic        lineout_l_mixer_enable,
	output var  logic        lineout_l_rmix_on,
	output var  logic        lineout_l_lmix_on
);

	// ==========================================================
	// register file
	logic [7:0]  cfg_q [NUM_REGS];
	logic [7:0]  rdata_q;
	logic        hit;
	logic [3:0]  idx;

	assign hit = reg_hit(reg_addr);
	assign idx = reg_index(reg_addr);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				cfg_q[i] <= REG_RESET[i];
			end
		end else if (ce && reg_wr && hit) begin
			// reserved bits read back zero
			cfg_q[idx] <= reg_wdata & REG_MASK[idx]; // RL17
		end
	end

	// unmapped reads return zero; data is held until the next read
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (ce && reg_rd) begin
			rdata_q <= hit ? cfg_q[idx] : 8'h00;
		end
	end

	assign reg_rdata = rdata_q;

	// ==========================================================
	// field views
	logic [7:0] adc_r;
	logic [7:0] lm0;
	logic [7:0] lm1;
	logic [7:0] rm0;
	logic [7:0] rm1;
	logic [7:0] lo;

	assign adc_r = cfg_q[IDX_ADC];
	assign lm0   = cfg_q[IDX_LMIX0];
	assign lm1   = cfg_q[IDX_LMIX1];
	assign rm0   = cfg_q[IDX_RMIX0];
	assign rm1   = cfg_q[IDX_RMIX1];
	assign lo    = cfg_q[IDX_LOUT];

	assign adc_slot_pair       = cfg_q[IDX_TDM][SLOT_PAIR_LSB +: 2];
	assign tdm_left_slot       = {adc_slot_pair, 1'b0}; // RL1
	assign tdm_right_slot      = {adc_slot_pair, 1'b1}; // RL1
	assign adc_channel_enable  = adc_r[ADC_EN_LSB +: 2];
	assign adc_highpass_on     = adc_r[HPF_BIT];
	assign input_source_select = adc_r[SRC_SEL_BIT];

	assign lmix_rdac_unmute  = lm0[MIX_RDAC_BIT]; // RL9
	assign lmix_ldac_unmute  = lm0[MIX_LDAC_BIT]; // RL9
	assign lmix_aux_gain     = lm0[MIX_AUX_LSB +: 4]; // RL10
	assign lmix_enable       = lm0[MIX_EN_BIT]; // RL11
	assign lmix_rbypass_gain = lm1[BYP_R_LSB +: 4]; // RL12
	assign lmix_lbypass_gain = lm1[BYP_L_LSB +: 4]; // RL12
	assign rmix_rdac_unmute  = rm0[MIX_RDAC_BIT]; // RL13
	assign rmix_ldac_unmute  = rm0[MIX_LDAC_BIT]; // RL13
	assign rmix_aux_gain     = rm0[MIX_AUX_LSB +: 4]; // RL14
	assign rmix_enable       = rm0[MIX_EN_BIT]; // RL15
	assign rmix_rbypass_gain = rm1[BYP_R_LSB +: 4]; // RL12
	assign rmix_lbypass_gain = rm1[BYP_L_LSB +: 4]; // RL12

	assign lineout_l_from_rmix_boost = lo[LO_RMIX_LSB +: 2]; // RL16
	assign lineout_l_from_lmix_boost = lo[LO_LMIX_LSB +: 2]; // RL16
	assign lineout_l_mixer_enable    = lo[LO_EN_BIT]; // RL16

	// ==========================================================
	// decoded mixer gains
	// decode trails the register by a cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lmix_aux_db     <= 6'h00;
			lmix_lbypass_db <= 6'h00;
			lmix_rbypass_db <= 6'h00;
			rmix_aux_db     <= 6'h00;
			rmix_lbypass_db <= 6'h00;
			rmix_rbypass_db <= 6'h00;
			mix_gain_mute   <= 6'h3f;
		end else if (ce) begin
			lmix_aux_db     <= gain_db(lmix_aux_gain); // RL10
			lmix_lbypass_db <= gain_db(lmix_lbypass_gain); // RL12
			lmix_rbypass_db <= gain_db(lmix_rbypass_gain); // RL12
			rmix_aux_db     <= gain_db(rmix_aux_gain); // RL14
			rmix_lbypass_db <= gain_db(rmix_lbypass_gain); // RL12
			rmix_rbypass_db <= gain_db(rmix_rbypass_gain); // RL12
			mix_gain_mute   <= {
				gain_mute(rmix_rbypass_gain), // RL12
				gain_mute(rmix_lbypass_gain), // RL12
				gain_mute(rmix_aux_gain), // RL14
				gain_mute(lmix_rbypass_gain), // RL12
				gain_mute(lmix_lbypass_gain), // RL12
				gain_mute(lmix_aux_gain)}; // RL10
		end
	end

	// reserved boost code 11 is kept off rather than guessed at
	function automatic logic boost_on(input logic en, input logic [1:0] code);
		return en && code != 2'b00 && code != 2'b11;
	endfunction

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lineout_l_rmix_on <= 1'b0;
			lineout_l_lmix_on <= 1'b0;
		end else if (ce) begin
			lineout_l_rmix_on <= boost_on(lineout_l_mixer_enable, lineout_l_from_rmix_boost); // RL16
			lineout_l_lmix_on <= boost_on(lineout_l_mixer_enable, lineout_l_from_lmix_boost); // RL16
		end
	end

	// ==========================================================
	// volume slewing
	logic l_settled;
	logic r_settled;

	atten_slew u_lslew (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.ce        (ce),
		.target    (cfg_q[IDX_LVOL]),
		.level_q   (left_input_atten),
		.settled_q (l_settled)
	);

	atten_slew u_rslew (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.ce        (ce),
		.target    (cfg_q[IDX_RVOL]),
		.level_q   (right_input_atten),
		.settled_q (r_settled)
	);

	// both sides must land before settled
	assign atten_settled = l_settled & r_settled;

	// ==========================================================
	// record path, stage one: source, polarity, high-pass
	function automatic logic signed [23:0] neg24(input logic signed [23:0] x);
		// most negative value saturates instead of wrapping
		return (x == 24'sh80_0000) ? 24'sh7f_ffff : -x;
	endfunction

	function automatic logic signed [23:0] sat24(input logic signed [31:0] x);
		logic signed [23:0] y;
		y = x[23:0];
		if (x > 32'sh007f_ffff) begin
			y = 24'sh7f_ffff;
		end else if (x < -32'sh0080_0000) begin
			y = 24'sh80_0000;
		end
		return y;
	endfunction

	// sign flip shared by both sources
	function automatic logic signed [23:0] flip24(input logic signed [23:0] x, input logic inv);
		return inv ? neg24(x) : x;
	endfunction

	logic signed [23:0] adc_in [2];
	logic signed [23:0] mic_in [2];
	logic signed [23:0] src    [2];
	logic signed [31:0] hp_y   [2];
	logic signed [23:0] hpx_q  [2];
	logic signed [31:0] hpy_q  [2];
	logic signed [23:0] st1_q  [2];
	logic               st1_valid_q;

	always_comb begin
		adc_in[0] = adc_l_sample;
		adc_in[1] = adc_r_sample;
		mic_in[0] = adc_r[DMIC_SWAP_BIT] ? dmic_r_sample : dmic_l_sample; // RL5
		mic_in[1] = adc_r[DMIC_SWAP_BIT] ? dmic_l_sample : dmic_r_sample; // RL5
		for (int c = 0; c < 2; c++) begin
			if (input_source_select) begin
				src[c] = flip24(mic_in[c], !adc_r[DMIC_POL_BIT]); // RL4
			end else begin
				src[c] = flip24(adc_in[c], adc_r[ADC_INV_BIT]); // RL2
			end
			// one-pole dc blocker; shift of 12 puts the corner near 2 Hz at 48 kHz
			hp_y[c] = 32'(src[c]) - 32'(hpx_q[c]) + hpy_q[c]
				- (hpy_q[c] >>> HPF_SHIFT); // RL3
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int c = 0; c < 2; c++) begin
				hpx_q[c] <= 24'sh00_0000;
				hpy_q[c] <= 32'sh0000_0000;
				st1_q[c] <= 24'sh00_0000;
			end
		end else if (ce && sample_valid) begin
			for (int c = 0; c < 2; c++) begin
				if (adc_highpass_on && adc_channel_enable[c]) begin
					hpx_q[c] <= src[c]; // RL3
					hpy_q[c] <= hp_y[c]; // RL3
					st1_q[c] <= sat24(hp_y[c]); // RL3
				end else begin
					// filter state restarts clean when it is switched back on
					hpx_q[c] <= 24'sh00_0000;
					hpy_q[c] <= 32'sh0000_0000;
					st1_q[c] <= src[c];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st1_valid_q <= 1'b0;
		end else if (ce) begin
			st1_valid_q <= sample_valid;
		end
	end

	// ==========================================================
	// record path, stage two: digital volume
	logic [7:0]         att   [2];
	logic signed [40:0] prod  [2];
	logic signed [40:0] scal  [2];

	assign att[0] = left_input_atten;
	assign att[1] = right_input_atten;

	// 16 steps make 6 dB: high nibble shifts, low nibble picks the fraction
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			prod[c] = 41'(st1_q[c]) * 41'($signed({1'b0, atten_frac(att[c][3:0])})); // RL7
			scal[c] = prod[c] >>> (5'(FRAC_SHIFT) + {1'b0, att[c][7:4]}); // RL7
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rec_l_sample <= 24'h00_0000;
			rec_r_sample <= 24'h00_0000;
			rec_l_valid  <= 1'b0;
			rec_r_valid  <= 1'b0;
		end else if (ce) begin
			rec_l_valid <= st1_valid_q && adc_channel_enable[0]; // RL6
			rec_r_valid <= st1_valid_q && adc_channel_enable[1]; // RL6
			if (st1_valid_q) begin
				// same volume stage whatever the source was
				rec_l_sample <= adc_channel_enable[0] ? scal[0][23:0] : 24'h00_0000; // RL8
				rec_r_sample <= adc_channel_enable[1] ? scal[1][23:0] : 24'h00_0000; // RL8
			end
		end
	end

endmodule // codec_adc_mixer_config_regs

`default_nettype wire

// ==== hw/codec_cfg_pkg.sv ====
package codec_cfg_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_MHZ          = 200;
	// one attenuation step of 0.375 dB is taken per slew interval
	localparam int unsigned SLEW_STEP_NS     = 1000;
	localparam int unsigned SLEW_STEP_CYCLES =
		(SLEW_STEP_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
		(SLEW_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SLEW_CNT_W       = 12;

	// ==========================================================
	// register map
	localparam int unsigned NUM_REGS   = 9;
	localparam logic [15:0] REG_BASE   = 16'h4018;
	localparam logic [15:0] OFS_TDM    = 16'h4018;
	localparam logic [15:0] OFS_ADC    = 16'h4019;
	localparam logic [15:0] OFS_LVOL   = 16'h401a;
	localparam logic [15:0] OFS_RVOL   = 16'h401b;
	localparam logic [15:0] OFS_LMIX0  = 16'h401c;
	localparam logic [15:0] OFS_LMIX1  = 16'h401d;
	localparam logic [15:0] OFS_RMIX0  = 16'h401e;
	localparam logic [15:0] OFS_RMIX1  = 16'h401f;
	localparam logic [15:0] OFS_LOUT   = 16'h4020;

	localparam logic [3:0] IDX_TDM   = 4'h0;
	localparam logic [3:0] IDX_ADC   = 4'h1;
	localparam logic [3:0] IDX_LVOL  = 4'h2;
	localparam logic [3:0] IDX_RVOL  = 4'h3;
	localparam logic [3:0] IDX_LMIX0 = 4'h4;
	localparam logic [3:0] IDX_LMIX1 = 4'h5;
	localparam logic [3:0] IDX_RMIX0 = 4'h6;
	localparam logic [3:0] IDX_RMIX1 = 4'h7;
	localparam logic [3:0] IDX_LOUT  = 4'h8;

	// writable bits; everything else is reserved and reads zero
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{
		8'h03, 8'h7f, 8'hff, 8'hff, 8'h7f, 8'hff, 8'h7f, 8'hff, 8'h1f};
	localparam logic [7:0] REG_RESET [NUM_REGS] = '{
		8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// ==========================================================
	// field positions
	localparam int unsigned SLOT_PAIR_LSB  = 0;
	localparam int unsigned ADC_INV_BIT    = 6;
	localparam int unsigned HPF_BIT        = 5;
	localparam int unsigned DMIC_POL_BIT   = 4;
	localparam int unsigned DMIC_SWAP_BIT  = 3;
	localparam int unsigned SRC_SEL_BIT    = 2;
	localparam int unsigned ADC_EN_LSB     = 0;
	localparam int unsigned MIX_RDAC_BIT   = 6;
	localparam int unsigned MIX_LDAC_BIT   = 5;
	localparam int unsigned MIX_AUX_LSB    = 1;
	localparam int unsigned MIX_EN_BIT     = 0;
	localparam int unsigned BYP_R_LSB      = 4;
	localparam int unsigned BYP_L_LSB      = 0;
	localparam int unsigned LO_RMIX_LSB    = 3;
	localparam int unsigned LO_LMIX_LSB    = 1;
	localparam int unsigned LO_EN_BIT      = 0;

	// ==========================================================
	// gain coding and record path
	localparam logic [3:0] GAIN_CODE_MAX  = 4'h8;
	localparam logic [5:0] GAIN_STEP_DB   = 6'h03;
	localparam logic [5:0] GAIN_OFFSET_DB = 6'h12;
	localparam int unsigned HPF_SHIFT     = 12;
	localparam int unsigned FRAC_SHIFT    = 15;

	function automatic logic reg_hit(input logic [15:0] addr);
		return addr >= REG_BASE && addr < REG_BASE + 16'(NUM_REGS);
	endfunction

	function automatic logic [3:0] reg_index(input logic [15:0] addr);
		logic [15:0] d;
		d = addr - REG_BASE;
		return d[3:0];
	endfunction

	// mixer gain code to signed dB: 1 -> -15 dB, 3 dB per code
	function automatic logic [5:0] gain_db(input logic [3:0] code);
		logic [5:0] db;
		db = 6'h00;
		if (code != 4'h0 && code <= GAIN_CODE_MAX) begin
			db = 6'({2'b00, code} * GAIN_STEP_DB) - GAIN_OFFSET_DB;
		end
		return db;
	endfunction

	// reserved codes above the top step are treated as mute
	function automatic logic gain_mute(input logic [3:0] code);
		return code == 4'h0 || code > GAIN_CODE_MAX;
	endfunction

	// linear factor for 0..15 steps of 0.375 dB, q1.15
	function automatic logic [15:0] atten_frac(input logic [3:0] r);
		logic [15:0] f;
		unique case (r)
			4'h0: f = 16'h8000;
			4'h1: f = 16'h7a98;
			4'h2: f = 16'h756a;
			4'h3: f = 16'h7074;
			4'h4: f = 16'h6bb3;
			4'h5: f = 16'h6726;
			4'h6: f = 16'h62ca;
			4'h7: f = 16'h5e9e;
			4'h8: f = 16'h5a9e;
			4'h9: f = 16'h56ca;
			4'ha: f = 16'h531f;
			4'hb: f = 16'h4f9c;
			4'hc: f = 16'h4c3f;
			4'hd: f = 16'h4906;
			4'he: f = 16'h45f0;
			4'hf: f = 16'h42fc;
		endcase
		return f;
	endfunction

endpackage
